// ===== rtl/ccce_engine.sv
// card-side command engine: activation, authentication, read, write, value ops
`timescale 1ns/1ps
`include "ccce_map.svh"

// Function
// - sequence one: cl1 then cl2 select
// - sequence two: cl1 then read block 0
// - sequence three: cl1 select alone activates
// - allowed sequences follow the uid option
// - block 0 in sequence two: plain, unauthenticated
// - otherwise reads need sector auth, encrypted
// - request answer independent of uid option
// - auth uid bytes depend on sequence
// - four-byte identifier uses cascade level one only
// - four-byte variant: auth input is uid
// - auth part one: 60h/61h, address
// - challenge four bytes, token eight, reply four
// - block address is one full byte
// - no answer before 71 us; silent value part two
// - read 30h returns sixteen bytes or nak
// - write A0h acked, then sixteen bytes stored
// - increment sums into volatile register
// - decrement subtracts into volatile register
// - restore copies into volatile register
// - value part one nak on bad block
// - ack is Ah, nak any other nibble
// - new uid option effective after unselect
module ccce_engine
#(
	parameter int NUM_BLOCKS    = `CCCE_NUM_BLOCKS,
	parameter int REPLY_MIN_CYC =
		(`CCCE_T_REPLY_MIN_NS * 1000 + `CCCE_CLK_PERIOD_PS - 1) / `CCCE_CLK_PERIOD_PS
)
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [1:0]  uid_option,
	input  wire logic        uid_is_4byte,
	input  wire logic        cl1_selected,
	input  wire logic        cl2_selected,
	input  wire logic        deselect,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_last,
	input  wire logic        tx_ready,
	output logic      [15:0] atqa,
	output logic      [31:0] auth_uid,
	output logic             card_active,
	output logic             tx_valid,
	output logic      [7:0]  tx_data,
	output logic             tx_last,
	output logic             tx_nibble,
	output logic             tx_crypt,
	output logic      [31:0] volatile_value
);

	localparam int BW = `CCCE_BLK_W;
	localparam int SW = $clog2(REPLY_MIN_CYC + 2);
	localparam logic [SW-1:0] SINCE_MAX = '1;   // saturation point
	localparam logic [SW-1:0] MIN_GAP   = SW'(REPLY_MIN_CYC);

	// ============================================================
	// state
	logic [1:0]             opt_q;        // effective uid option
	logic                   four_q;       // four-byte identifier variant
	logic                   opt_ld_q;     // option captured since reset
	logic [15:0]            atqa_q;       // request answer value
	ccce_pkg::ccce_act_type act_q;        // activation state
	ccce_pkg::ccce_seq_type seq_q;        // sequence used
	logic [31:0]            uid_q;        // auth uid bytes
	logic [BW-1:0]          rx_buf_q;     // received frame payload
	logic [4:0]             rx_cnt_q;     // bytes received
	logic                   proc_q;       // frame complete, decode now
	logic [SW-1:0]          since_q;      // cycles since reader frame end
	ccce_pkg::ccce_pend_type pend_q;      // awaited second part
	logic [7:0]             pend_addr_q;  // block of the pending command
	logic [7:0]             pend_op_q;    // opcode of the pending command
	logic                   authed_q;     // a sector is authenticated
	logic [5:0]             auth_sec_q;   // that sector
	logic [31:0]            lfsr_q;       // challenge generator
	logic [31:0]            vol_q;        // volatile value register
	ccce_pkg::ccce_tx_type  tx_st_q;      // answer sender state
	logic [BW-1:0]          rep_buf_q;    // answer bytes
	logic [4:0]             rep_len_q;    // answer length
	logic [4:0]             tx_idx_q;     // byte being sent
	logic [7:0]             rep_addr_q;   // block the answer came from
	logic                   tx_valid_q;
	logic [7:0]             tx_data_q;
	logic                   tx_last_q;
	logic                   tx_nib_q;
	logic                   tx_crypt_q;

	// ============================================================
	// decode results
	logic                    d_rep;     // arm an answer
	logic                    d_nib;     // answer is a nibble
	logic                    d_crypt;   // answer goes out encrypted
	logic [4:0]              d_len;
	logic [BW-1:0]           d_buf;
	ccce_pkg::ccce_pend_type d_pend;
	logic                    d_wr;      // store block
	logic                    d_vol_wr;  // load volatile register
	logic [31:0]             d_vol;
	logic                    d_auth;    // authentication completes
	logic                    d_seq2;    // sequence two completes
	logic [7:0]              cmd;
	logic [7:0]              addr;
	logic [7:0]              rd_idx;
	logic [BW-1:0]           rd_blk;
	logic [BW-1:0]           blk0;
	logic                    addr_ok;
	logic                    sec_ok;

	// ============================================================
	// helpers
	// nibble answer in the low byte
	function automatic logic [BW-1:0] nib_word(input logic [3:0] code);
		nib_word = {{(BW-4){1'b0}}, code};
	endfunction

	// well-formed value block: v, ~v, v, addr, ~addr, addr, ~addr
	function automatic logic is_value_blk(input logic [BW-1:0] b);
		logic [31:0] v;
		v = b[31:0];
		is_value_blk = (b[63:32] == ~v) && (b[95:64] == v) &&
			(b[111:104] == ~b[103:96]) && (b[111:104] == ~b[119:112]) &&
			(b[103:96] == ~b[127:120]);
	endfunction

	assign cmd     = rx_buf_q[7:0];
	assign addr    = rx_buf_q[15:8];               // full byte address
	assign rd_idx  = (pend_q != ccce_pkg::CCCE_PEND_NONE) ? pend_addr_q : addr;
	assign addr_ok = int'(addr) < NUM_BLOCKS;
	assign sec_ok  = authed_q && (auth_sec_q == addr[7:`CCCE_SECTOR_LSB]);

	// ============================================================
	// block store
	ccce_block_mem #(.NUM_BLOCKS(NUM_BLOCKS), .BLK_W(BW)) u_mem
	(
		.clk       (clk),
		.arst_n    (arst_n),
		.wr_en     (d_wr),
		.wr_idx    (pend_addr_q),
		.wr_data   (rx_buf_q),
		.rd_idx    (rd_idx),
		.rd_data   (rd_blk),
		.blk0_data (blk0)
	);

	// ============================================================
	// uid option and request answer, captured after reset or unselect
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			opt_q    <= 2'd0;
			four_q   <= 1'b0;
			opt_ld_q <= 1'b0;
			atqa_q   <= `CCCE_ATQA_7BYTE;
		end
		else if (!opt_ld_q || deselect)
		begin
			opt_q    <= uid_option;
			four_q   <= uid_is_4byte;
			opt_ld_q <= 1'b1;
			atqa_q   <= uid_is_4byte ? `CCCE_ATQA_4BYTE : `CCCE_ATQA_7BYTE;
		end
	end

	// ============================================================
	// activation sequences
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			act_q <= ccce_pkg::CCCE_ACT_IDLE;
			seq_q <= ccce_pkg::CCCE_SEQ_NONE;
			uid_q <= 32'h0000_0000;
		end
		else if (deselect)
		begin
			act_q <= ccce_pkg::CCCE_ACT_IDLE;
			seq_q <= ccce_pkg::CCCE_SEQ_NONE;
		end
		else
		begin
			case (act_q)
				ccce_pkg::CCCE_ACT_IDLE:
				begin
					// options two, three and four-byte: cl1 alone
					if (cl1_selected && (four_q || opt_q[1]))
					begin
						act_q <= ccce_pkg::CCCE_ACT_ON;
						seq_q <= ccce_pkg::CCCE_SEQ_3;
						uid_q <= blk0[31:0];   // uid0..uid3
					end
					else if (cl1_selected)
						act_q <= ccce_pkg::CCCE_ACT_CL1;
				end
				ccce_pkg::CCCE_ACT_CL1:
				begin
					if (cl2_selected)
					begin
						act_q <= ccce_pkg::CCCE_ACT_ON;
						seq_q <= ccce_pkg::CCCE_SEQ_1;
						uid_q <= blk0[55:24];   // uid3..uid6
					end
					else if (d_seq2)
					begin
						act_q <= ccce_pkg::CCCE_ACT_ON;
						seq_q <= ccce_pkg::CCCE_SEQ_2;
						uid_q <= {blk0[23:0], `CCCE_CASCADE_TAG};   // tag, uid0..uid2
					end
				end
				default:
					act_q <= ccce_pkg::CCCE_ACT_ON;
			endcase
		end
	end

	// ============================================================
	// frame collection
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_buf_q <= '0;
			rx_cnt_q <= 5'd0;
			proc_q   <= 1'b0;
		end
		else
		begin
			proc_q <= rx_valid && rx_last;
			if (proc_q)
				rx_cnt_q <= 5'd0;
			else if (rx_valid && (rx_cnt_q <= `CCCE_LEN_BLOCK))
			begin
				if (rx_cnt_q < `CCCE_LEN_BLOCK)
					rx_buf_q[{rx_cnt_q[3:0], 3'b000} +: 8] <= rx_data;
				rx_cnt_q <= rx_cnt_q + 5'd1;   // seventeen marks overlong
			end
		end
	end

	// ============================================================
	// frame decode
	always_comb
	begin
		d_rep    = 1'b0;
		d_nib    = 1'b0;
		d_crypt  = 1'b1;
		d_len    = `CCCE_LEN_NIBBLE;
		d_buf    = nib_word(`CCCE_NAK);
		d_pend   = ccce_pkg::CCCE_PEND_NONE;
		d_wr     = 1'b0;
		d_vol_wr = 1'b0;
		d_vol    = rd_blk[31:0];
		d_auth   = 1'b0;
		d_seq2   = 1'b0;
		if (proc_q && (act_q == ccce_pkg::CCCE_ACT_CL1))
		begin
			// shortcut read of block 0: plain, no auth
			if ((opt_q == 2'd1) && !four_q && (cmd == `CCCE_OP_READ) &&
				(rx_cnt_q == `CCCE_LEN_CMD) && (addr == 8'h00))
			begin
				d_rep   = 1'b1;
				d_crypt = 1'b0;
				d_len   = `CCCE_LEN_BLOCK;
				d_buf   = blk0;
				d_seq2  = 1'b1;
			end
		end
		else if (proc_q && (act_q == ccce_pkg::CCCE_ACT_ON))
		begin
			case (pend_q)
				ccce_pkg::CCCE_PEND_AUTH:
				begin
					// token in, token out; wrong length stays silent
					if (rx_cnt_q == `CCCE_LEN_TOKEN_RX)
					begin
						d_rep  = 1'b1;
						d_len  = `CCCE_LEN_TOKEN_TX;
						d_buf  = {{(BW-32){1'b0}}, lfsr_q};
						d_auth = 1'b1;
					end
				end
				ccce_pkg::CCCE_PEND_WRITE:
				begin
					d_rep = 1'b1;
					d_nib = 1'b1;
					if (rx_cnt_q == `CCCE_LEN_BLOCK)
					begin
						d_wr  = 1'b1;
						d_buf = nib_word(`CCCE_ACK);
					end
				end
				ccce_pkg::CCCE_PEND_VALUE:
				begin
					// operand in, no answer at all
					d_vol_wr = (rx_cnt_q == `CCCE_LEN_OPERAND);
					if (pend_op_q == `CCCE_OP_INC)
						d_vol = rd_blk[31:0] + rx_buf_q[31:0];
					else if (pend_op_q == `CCCE_OP_DEC)
						d_vol = rd_blk[31:0] - rx_buf_q[31:0];
					else
						d_vol = rd_blk[31:0];
				end
				default:
				begin
					d_rep = (rx_cnt_q == `CCCE_LEN_CMD);
					d_nib = 1'b1;
					if ((cmd == `CCCE_OP_AUTH_A) || (cmd == `CCCE_OP_AUTH_B))
					begin
						if (addr_ok)   // challenge goes out plain
						begin
							d_nib   = 1'b0;
							d_crypt = 1'b0;
							d_len   = `CCCE_LEN_CHAL;
							d_buf   = {{(BW-32){1'b0}}, lfsr_q};
							d_pend  = ccce_pkg::CCCE_PEND_AUTH;
						end
					end
					else if (cmd == `CCCE_OP_READ)
					begin
						if (addr_ok && sec_ok)   // encrypted block
						begin
							d_nib = 1'b0;
							d_len = `CCCE_LEN_BLOCK;
							d_buf = rd_blk;
						end
					end
					else if (cmd == `CCCE_OP_WRITE)
					begin
						if (addr_ok && sec_ok)
						begin
							d_buf  = nib_word(`CCCE_ACK);
							d_pend = ccce_pkg::CCCE_PEND_WRITE;
						end
					end
					else if ((cmd == `CCCE_OP_INC) || (cmd == `CCCE_OP_DEC) ||
						(cmd == `CCCE_OP_RESTORE))
					begin
						if (addr_ok && sec_ok && is_value_blk(rd_blk))
						begin
							d_buf  = nib_word(`CCCE_ACK);
							d_pend = ccce_pkg::CCCE_PEND_VALUE;
						end
					end
					if (rx_cnt_q != `CCCE_LEN_CMD)
						d_pend = ccce_pkg::CCCE_PEND_NONE;
				end
			endcase
		end
	end

	// ============================================================
	// pending part, authentication, volatile register, challenge generator
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pend_q      <= ccce_pkg::CCCE_PEND_NONE;
			pend_addr_q <= 8'h00;
			pend_op_q   <= 8'h00;
			authed_q    <= 1'b0;
			auth_sec_q  <= 6'h00;
			vol_q       <= 32'h0000_0000;
			lfsr_q      <= `CCCE_LFSR_SEED;
		end
		else
		begin
			lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ `CCCE_LFSR_TAPS) : (lfsr_q >> 1);
			if (deselect)
			begin
				pend_q   <= ccce_pkg::CCCE_PEND_NONE;
				authed_q <= 1'b0;
			end
			else if (proc_q && (act_q == ccce_pkg::CCCE_ACT_ON))
			begin
				pend_q <= d_pend;
				if (pend_q == ccce_pkg::CCCE_PEND_NONE)
				begin
					pend_addr_q <= addr;
					pend_op_q   <= cmd;
				end
				if (d_auth)
				begin
					authed_q   <= 1'b1;
					auth_sec_q <= pend_addr_q[7:`CCCE_SECTOR_LSB];
				end
				if (d_vol_wr)
					vol_q <= d_vol;
			end
		end
	end

	// ============================================================
	// answer sender, held back by the least frame delay
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			since_q <= '0;
		else if (rx_valid && rx_last)
			since_q <= '0;
		else if (since_q != SINCE_MAX)
			since_q <= since_q + 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_st_q    <= ccce_pkg::CCCE_TX_IDLE;
			rep_buf_q  <= '0;
			rep_len_q  <= 5'd0;
			rep_addr_q <= 8'h00;
			tx_idx_q   <= 5'd0;
			tx_valid_q <= 1'b0;
			tx_data_q  <= 8'h00;
			tx_last_q  <= 1'b0;
			tx_nib_q   <= 1'b0;
			tx_crypt_q <= 1'b0;
		end
		else
		begin
			case (tx_st_q)
				ccce_pkg::CCCE_TX_IDLE:
				begin
					if (proc_q && d_rep)
					begin
						tx_st_q    <= ccce_pkg::CCCE_TX_WAIT;
						rep_buf_q  <= d_buf;
						rep_len_q  <= d_len;
						rep_addr_q <= addr;
						tx_nib_q   <= d_nib;
						tx_crypt_q <= d_crypt;
					end
				end
				ccce_pkg::CCCE_TX_WAIT:
				begin
					if (since_q >= MIN_GAP)
					begin
						tx_st_q    <= ccce_pkg::CCCE_TX_SEND;
						tx_valid_q <= 1'b1;
						tx_data_q  <= rep_buf_q[7:0];
						tx_last_q  <= (rep_len_q == 5'd1);
						tx_idx_q   <= 5'd0;
					end
				end
				default:
				begin
					if (tx_ready && tx_last_q)
					begin
						tx_st_q    <= ccce_pkg::CCCE_TX_IDLE;
						tx_valid_q <= 1'b0;
						tx_last_q  <= 1'b0;
					end
					else if (tx_ready)
					begin
						tx_idx_q  <= tx_idx_q + 5'd1;
						tx_data_q <= rep_buf_q[{tx_idx_q[3:0] + 4'd1, 3'b000} +: 8];
						tx_last_q <= (tx_idx_q + 5'd2 == rep_len_q);
					end
				end
			endcase
		end
	end

	// ============================================================
	// outputs
	assign atqa           = atqa_q;
	assign auth_uid       = uid_q;
	assign card_active    = (act_q == ccce_pkg::CCCE_ACT_ON);
	assign tx_valid       = tx_valid_q;
	assign tx_data        = tx_data_q;
	assign tx_last        = tx_last_q;
	assign tx_nibble      = tx_nib_q;
	assign tx_crypt       = tx_crypt_q;
	assign volatile_value = vol_q;

	// ============================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_cl1_direct;
		(act_q == ccce_pkg::CCCE_ACT_IDLE) && cl1_selected && !deselect && (four_q || opt_q[1]);
	endsequence
	sequence s_cl1_then_cl2;
		(act_q == ccce_pkg::CCCE_ACT_CL1) && cl2_selected && !deselect;
	endsequence

	property p_reply_gap;
		$rose(tx_valid_q) |-> (since_q > MIN_GAP);
	endproperty
	a_reply_gap: assert property (p_reply_gap) else $error("answer before least delay");

	property p_seq3;
		s_cl1_direct |=> card_active && (seq_q == ccce_pkg::CCCE_SEQ_3) && (uid_q == $past(blk0[31:0]));
	endproperty
	a_seq3: assert property (p_seq3) else $error("cl1 alone did not activate");

	property p_seq1_uid;
		s_cl1_then_cl2 |=> (seq_q == ccce_pkg::CCCE_SEQ_1) && (uid_q == $past(blk0[55:24]));
	endproperty
	a_seq1_uid: assert property (p_seq1_uid) else $error("sequence one uid bytes wrong");

	property p_option_seq;
		card_active |-> (opt_q[1] || four_q) ? (seq_q == ccce_pkg::CCCE_SEQ_3) :
			((seq_q != ccce_pkg::CCCE_SEQ_3) && ((seq_q != ccce_pkg::CCCE_SEQ_2) || (opt_q == 2'd1)));
	endproperty
	a_option_seq: assert property (p_option_seq) else $error("sequence not allowed by option");

	property p_atqa;
		($changed(opt_q) && $stable(four_q)) |-> $stable(atqa_q);
	endproperty
	a_atqa: assert property (p_atqa) else $error("request answer follows option");

	property p_plain_block;
		(tx_valid_q && !tx_crypt_q && (rep_len_q == `CCCE_LEN_BLOCK)) |->
			((rep_addr_q == 8'h00) && (seq_q == ccce_pkg::CCCE_SEQ_2));
	endproperty
	a_plain_block: assert property (p_plain_block) else $error("plain block outside shortcut");

	property p_value_silent;
		(proc_q && card_active && (pend_q == ccce_pkg::CCCE_PEND_VALUE)) |=>
			(tx_st_q == ccce_pkg::CCCE_TX_IDLE) [*2];
	endproperty
	a_value_silent: assert property (p_value_silent) else $error("answer to value part two");

	property p_increment;
		(proc_q && card_active && !deselect && (pend_q == ccce_pkg::CCCE_PEND_VALUE) &&
			(pend_op_q == `CCCE_OP_INC) && (rx_cnt_q == `CCCE_LEN_OPERAND)) |=>
			(vol_q == $past(rd_blk[31:0]) + $past(rx_buf_q[31:0]));
	endproperty
	a_increment: assert property (p_increment) else $error("increment sum wrong");

	property p_bad_value_nak;
		(proc_q && card_active && !deselect && (pend_q == ccce_pkg::CCCE_PEND_NONE) &&
			(cmd == `CCCE_OP_DEC) && (rx_cnt_q == `CCCE_LEN_CMD) && !is_value_blk(rd_blk) &&
			(tx_st_q == ccce_pkg::CCCE_TX_IDLE)) |=>
			(rep_buf_q[3:0] == `CCCE_NAK) && (pend_q == ccce_pkg::CCCE_PEND_NONE);
	endproperty
	a_bad_value_nak: assert property (p_bad_value_nak) else $error("bad value block not refused");

endmodule // ccce_engine

// ===== shared/ccce_map.svh
// constants of the contactless card command engine: opcodes, codes, layouts, timing
`ifndef CCCE_MAP_SVH
`define CCCE_MAP_SVH

// ============================================================
// command opcodes, first byte of a reader frame
`define CCCE_OP_AUTH_A      8'h60
`define CCCE_OP_AUTH_B      8'h61
`define CCCE_OP_READ        8'h30
`define CCCE_OP_WRITE       8'hA0
`define CCCE_OP_DEC         8'hC0
`define CCCE_OP_INC         8'hC1
`define CCCE_OP_RESTORE     8'hC2

// ============================================================
// four-bit answer codes
`define CCCE_ACK            4'hA
`define CCCE_NAK            4'h4

// ============================================================
// identifier and request answer
`define CCCE_CASCADE_TAG    8'h88
`define CCCE_ATQA_7BYTE     16'h0044
`define CCCE_ATQA_4BYTE     16'h0004

// ============================================================
// frame payload lengths in bytes, crc already stripped
`define CCCE_LEN_CMD        5'd2
`define CCCE_LEN_BLOCK      5'd16
`define CCCE_LEN_TOKEN_RX   5'd8
`define CCCE_LEN_TOKEN_TX   5'd4
`define CCCE_LEN_CHAL       5'd4
`define CCCE_LEN_OPERAND    5'd4
`define CCCE_LEN_NIBBLE     5'd1

// ============================================================
// block geometry
`define CCCE_BLK_W          128
`define CCCE_NUM_BLOCKS     64
`define CCCE_SECTOR_LSB     2

// ============================================================
// timing: least frame delay before any answer
`define CCCE_T_REPLY_MIN_NS 71000
`define CCCE_CLK_PERIOD_PS  5000

// ============================================================
// challenge generator seed and feedback taps (seed value is arbitrary)
`define CCCE_LFSR_SEED      32'h1D5A0C3B
`define CCCE_LFSR_TAPS      32'h80200003

`endif

// ===== shared/ccce_pkg.sv
// types of the contactless card command engine
package ccce_pkg;

	// ============================================================
	// activation state, gray along idle -> cl1 -> active
	typedef enum logic [1:0]
	{
		CCCE_ACT_IDLE = 2'b00,
		CCCE_ACT_CL1  = 2'b01,
		CCCE_ACT_ON   = 2'b11
	} ccce_act_type;

	// ============================================================
	// pending second part of a two-part command
	typedef enum logic [1:0]
	{
		CCCE_PEND_NONE  = 2'b00,
		CCCE_PEND_AUTH  = 2'b01,
		CCCE_PEND_WRITE = 2'b11,
		CCCE_PEND_VALUE = 2'b10
	} ccce_pend_type;

	// ============================================================
	// answer sender, gray along idle -> wait -> send
	typedef enum logic [1:0]
	{
		CCCE_TX_IDLE = 2'b00,
		CCCE_TX_WAIT = 2'b01,
		CCCE_TX_SEND = 2'b11
	} ccce_tx_type;

	// ============================================================
	// activation sequence that brought the card up
	typedef enum logic [1:0]
	{
		CCCE_SEQ_NONE = 2'd0,
		CCCE_SEQ_1    = 2'd1,
		CCCE_SEQ_2    = 2'd2,
		CCCE_SEQ_3    = 2'd3
	} ccce_seq_type;

endpackage

// ===== rtl/ccce_block_mem.sv
// block store of the card: flip-flop blocks, one write port, two read ports
`timescale 1ns/1ps
`include "ccce_map.svh"

module ccce_block_mem
#(
	parameter int NUM_BLOCKS = `CCCE_NUM_BLOCKS,
	parameter int BLK_W      = `CCCE_BLK_W
)
(
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             wr_en,
	input  wire logic [7:0]       wr_idx,
	input  wire logic [BLK_W-1:0] wr_data,
	input  wire logic [7:0]       rd_idx,
	output logic      [BLK_W-1:0] rd_data,
	output logic      [BLK_W-1:0] blk0_data
);

	localparam int IW = $clog2(NUM_BLOCKS);

	logic [BLK_W-1:0] mem_q [NUM_BLOCKS];   // block contents

	// ============================================================
	// one write process per block
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BLOCKS; gi++)
		begin : g_blk
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					mem_q[gi] <= '0;
				else if (wr_en && (int'(wr_idx) == gi))
					mem_q[gi] <= wr_data;
			end
		end
	endgenerate

	// ============================================================
	// reads: out of range reads as zero
	always_comb
	begin
		if (int'(rd_idx) < NUM_BLOCKS)
			rd_data = mem_q[rd_idx[IW-1:0]];
		else
			rd_data = '0;
		blk0_data = mem_q[0];
	end

endmodule // ccce_block_mem

// ===== verif/ccce_reader_model.sv
// reader-side partner: sends frames, collects answers
`timescale 1ns/1ps
module ccce_reader_model
(
	input  wire logic       clk,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	input  wire logic       tx_nibble,
	input  wire logic       tx_crypt,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_last,
	output logic            tx_ready
);
	logic [7:0] got_q [$]; // answer bytes
	logic [1:0] flags;     // nibble and cipher flag of answer
	logic       slow = 0;  // drop ready every other cycle
	int         wait_cyc;  // idle cycles before answer
	initial
	begin
		rx_valid = 0;
		rx_data = 8'h00;
		rx_last = 0;
		tx_ready = 0;
	end
	// frame out, byte a cycle; line inverted once released
	task automatic send(input logic [7:0] f [$]);
		foreach (f[i])
		begin
			@(negedge clk);
			rx_valid = 1;
			rx_data = f[i];
			rx_last = (i == f.size() - 1);
		end
		@(negedge clk);
		rx_valid = 0;
		rx_last = 0;
		rx_data = ~rx_data;
	endtask
	// answer in; silence until limit leaves got_q empty
	task automatic recv(input int lim);
		got_q = {};
		wait_cyc = 0;
		repeat (lim)
		begin
			@(negedge clk);
			tx_ready = slow ? ~tx_ready : 1'b1;
			if (!tx_valid) wait_cyc++;
			else if (tx_ready)
			begin
				got_q.push_back(tx_data);
				flags = {tx_nibble, tx_crypt};
				if (tx_last) break;
			end
		end
		@(negedge clk);
		tx_ready = 0;
	endtask
endmodule // ccce_reader_model

// ===== verif/tb_top.sv
// self-checking bench of the card command engine
`timescale 1ns/1ps
module tb_top;
	localparam int RMIN = 8; // shortened least reply delay
	localparam logic [127:0] PAT = 128'h1F1E1D1C1B1A19181716151413121110;
	logic clk = 0, arst_n = 0, cl1 = 0, cl2 = 0, desel = 0, four = 0;
	logic [1:0] opt = 2'd2;
	logic rv, rl, tr, tv, tl, tn, tc, act;
	logic [7:0] rd, td, q [$];
	logic [15:0] atqa;
	logic [31:0] auid, vol;
	int fail_count = 0, checks = 0;
	always #2.5 clk = ~clk;
	ccce_engine #(.REPLY_MIN_CYC(RMIN)) u_dut (.clk(clk), .arst_n(arst_n), .uid_option(opt),
		.uid_is_4byte(four), .cl1_selected(cl1), .cl2_selected(cl2), .deselect(desel),
		.rx_valid(rv), .rx_data(rd), .rx_last(rl), .tx_ready(tr), .atqa(atqa),
		.auth_uid(auid), .card_active(act), .tx_valid(tv), .tx_data(td), .tx_last(tl),
		.tx_nibble(tn), .tx_crypt(tc), .volatile_value(vol));
	ccce_reader_model u_rdr (.clk(clk), .tx_valid(tv), .tx_data(td), .tx_last(tl),
		.tx_nibble(tn), .tx_crypt(tc), .rx_valid(rv), .rx_data(rd), .rx_last(rl),
		.tx_ready(tr));
	task automatic chk(input string n, input logic [127:0] got, input logic [127:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s exp %0h got %0h", n, exp, got);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one command, its answer length and delay
	// recv starts one cycle after the frame edge, so one idle cycle is not counted
	task automatic cmd(input logic [7:0] f [$], input int n);
		repeat (RMIN) @(negedge clk);
		u_rdr.send(f);
		u_rdr.recv(RMIN + 60);
		chk("answer length", u_rdr.got_q.size(), n);
		if (n > 0) chk("reply delay", (u_rdr.wait_cyc + 1) >= RMIN, 1);
	endtask
	// four-bit answer code
	task automatic code(input logic [3:0] c);
		chk("code", {u_rdr.flags[1], u_rdr.got_q[0][3:0]}, {1'b1, c});
	endtask
	// block answer as one word, with cipher flag
	task automatic blk(input logic [127:0] e, input logic c);
		logic [127:0] r;
		foreach (u_rdr.got_q[i]) r[8*i+:8] = u_rdr.got_q[i];
		chk("block", r, e);
		chk("cipher", u_rdr.flags[0], c);
	endtask
	// word to frame, byte 0 first
	task automatic wq(input logic [127:0] w);
		q = {};
		for (int i = 0; i < 16; i++) q.push_back(w[8*i+:8]);
	endtask
	// unselect, then activate under option o
	task automatic act_seq(input logic [1:0] o, input logic f4, input logic two);
		@(negedge clk);
		opt = o;
		four = f4;
		desel = 1;
		@(negedge clk);
		desel = 0;
		cl1 = 1;
		@(negedge clk);
		cl1 = 0;
		cl2 = two;
		@(negedge clk);
		cl2 = 0;
		@(negedge clk);
	endtask
	// read of block 1 refused, auth, write and encrypted read of block 0
	task automatic t_rw();
		cmd({8'h30, 8'h01}, 1);
		code(4'h4);
		cmd({8'h61, 8'h00}, 4);
		chk("challenge", u_rdr.flags[0], 0);
		wq(PAT);
		cmd(q[0:7], 4);
		chk("token", u_rdr.flags[0], 1);
		cmd({8'hA0, 8'h00}, 1);
		code(4'hA);
		cmd(q, 1);
		code(4'hA);
		u_rdr.slow = 1;
		cmd({8'h30, 8'h00}, 16);
		blk(PAT, 1);
		u_rdr.slow = 0;
		$display("test rw finished");
	endtask
	// value ops on block 1, bad source block 0
	task automatic t_val();
		logic [7:0] ops [3] = '{8'hC1, 8'hC0, 8'hC2};
		logic [31:0] ex [3] = '{32'h69, 32'h5F, 32'h64};
		cmd({8'hA0, 8'h01}, 1);
		wq({32'hFE01FE01, 32'h64, ~32'h64, 32'h64});
		cmd(q, 1);
		foreach (ops[i])
		begin
			cmd({ops[i], 8'h01}, 1);
			code(4'hA);
			cmd({8'h05, 8'h00, 8'h00, 8'h00}, 0);
			chk("value", vol, ex[i]);
		end
		cmd({8'hC0, 8'h00}, 1);
		code(4'h4);
		$display("test value finished");
	endtask
	// activation sequences and identifier bytes
	task automatic t_seq();
		act_seq(2'd0, 0, 1);
		chk("seq one", {act, auid}, {1'b1, 32'h16151413});
		act_seq(2'd1, 0, 0);
		cmd({8'h30, 8'h00}, 16);
		blk(PAT, 0);
		chk("seq two", {act, auid, atqa}, {1'b1, 32'h12111088, 16'h0044});
		act_seq(2'd0, 0, 0);
		cmd({8'h30, 8'h00}, 0);
		chk("no shortcut", act, 0);
		act_seq(2'd3, 1, 0);
		chk("four byte", {act, auid, atqa}, {1'b1, 32'h13121110, 16'h0004});
		$display("test sequences finished");
	endtask
	initial
	begin
		repeat (12) @(negedge clk);
		arst_n = 1;
		repeat (2) @(negedge clk);
		chk("reset atqa", atqa, 16'h0044);
		act_seq(2'd2, 0, 0);
		chk("seq three", act, 1);
		t_rw();
		t_val();
		t_seq();
		test_done();
	end
	// hang guard, well past the expected run
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		test_done();
	end
endmodule // tb_top
